// ### rtl/mrb_pkg.sv
// Package: register map, field layout and Modbus constants for the request builder
package mrb_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] MRB_OFF_CTRL = 8'h00;
	localparam logic [7:0] MRB_OFF_CMD = 8'h04;
	localparam logic [7:0] MRB_OFF_ADDR = 8'h08;
	localparam logic [7:0] MRB_OFF_STAT = 8'h0C;
	localparam logic [7:0] MRB_OFF_OFFS = 8'h10;
	localparam logic [7:0] MRB_OFF_RXD = 8'h14;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MRB_CTRL_START = 0;
	localparam int MRB_CMD_FUNC_LSB = 0;
	localparam int MRB_CMD_NODE_LSB = 8;
	localparam int MRB_CMD_SWAP_LSB = 24;
	localparam int MRB_STAT_BUSY = 0;
	localparam int MRB_STAT_DONE = 1;
	localparam int MRB_STAT_ERR = 2;
	localparam int MRB_STAT_BCAST = 3;
	localparam int MRB_STAT_CODE_LSB = 4;
	localparam logic [31:0] MRB_CMD_RESET = 32'h0000_0000;
	localparam logic [31:0] MRB_ADDR_RESET = 32'h0000_0000;
	// ----------------------------------------------------------------
	// AXI responses
	// ----------------------------------------------------------------
	localparam logic [1:0] MRB_RESP_OKAY = 2'h0;
	localparam logic [1:0] MRB_RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Modbus function codes, node limits, address windows
	// ----------------------------------------------------------------
	localparam logic [7:0] MRB_FC_RD_COIL = 8'h01;
	localparam logic [7:0] MRB_FC_RD_INBIT = 8'h02;
	localparam logic [7:0] MRB_FC_RD_HOLD = 8'h03;
	localparam logic [7:0] MRB_FC_RD_INREG = 8'h04;
	localparam logic [7:0] MRB_FC_WR_COIL = 8'h05;
	localparam logic [7:0] MRB_FC_WR_REG = 8'h06;
	localparam logic [7:0] MRB_FC_WR_COILS = 8'h0F;
	localparam logic [7:0] MRB_FC_WR_REGS = 8'h10;
	localparam logic [7:0] MRB_NODE_BCAST = 8'h00;
	localparam logic [7:0] MRB_NODE_MIN = 8'h01;
	localparam logic [7:0] MRB_NODE_MAX = 8'hF7;
	localparam int MRB_COIL_LO = 1;
	localparam int MRB_COIL_HI = 9999;
	localparam int MRB_INBIT_LO = 10001;
	localparam int MRB_INBIT_HI = 29999;
	localparam int MRB_INREG_LO = 30001;
	localparam int MRB_INREG_HI = 39999;
	localparam int MRB_HOLD_LO = 40001;
	localparam int MRB_HOLD_HI = 47999;
	localparam int MRB_HOLDM_HI = 49999;
	// ----------------------------------------------------------------
	// Byte-order options and error codes
	// ----------------------------------------------------------------
	localparam logic [1:0] MRB_SWAP_NONE = 2'h0;
	localparam logic [1:0] MRB_SWAP_WORD = 2'h1;
	localparam logic [1:0] MRB_SWAP_ALL = 2'h2;
	localparam logic [1:0] MRB_SWAP_BYTE = 2'h3;
	localparam logic [3:0] MRB_ERR_NONE = 4'h0;
	localparam logic [3:0] MRB_ERR_FUNC = 4'h1;
	localparam logic [3:0] MRB_ERR_NODE = 4'h2;
	localparam logic [3:0] MRB_ERR_RANGE = 4'h3;
	localparam logic [3:0] MRB_ERR_BCAST = 4'h4;
	localparam logic [1:0] MRB_LAST_BYTE = 2'h3;
endpackage

// ### rtl/mrb_swap.sv
// Byte reordering of one four-byte group ABCD by the byte-order option
`timescale 1ns/100ps
module mrb_swap
	import mrb_pkg::*;
(
	input wire logic [1:0] i_swap,
	input wire logic [31:0] i_word,
	output logic [31:0] o_word
);
	// ----------------------------------------------------------------
	// Reorder, A in the top byte
	// ----------------------------------------------------------------
	always_comb
	begin
		case (i_swap)
			MRB_SWAP_NONE: o_word = i_word;
			MRB_SWAP_WORD: o_word = {i_word[15:0], i_word[31:16]};
			MRB_SWAP_ALL: o_word = {i_word[7:0], i_word[15:8], i_word[23:16], i_word[31:24]};
			MRB_SWAP_BYTE: o_word = {i_word[23:16], i_word[31:24], i_word[7:0], i_word[15:8]};
			default: o_word = i_word;
		endcase
	end
endmodule // mrb_swap

// ### rtl/mrb_addr_map.sv
// Function code, node and printed address check, and remote offset mapping
`timescale 1ns/100ps
module mrb_addr_map
	import mrb_pkg::*;
#(
	parameter int ADDR_W = 17
)
(
	input wire logic [7:0] i_func,
	input wire logic [7:0] i_node,
	input wire logic [ADDR_W-1:0] i_maddr,
	output logic o_ok,
	output logic [3:0] o_err,
	output logic o_bcast,
	output logic [15:0] o_remote_offset
);
	// Inclusive window test on the printed address
	function automatic logic in_win(input logic [ADDR_W-1:0] a, input int lo, input int hi);
		in_win = (int'(a) >= lo) && (int'(a) <= hi);
	endfunction

	logic known;
	logic is_write;
	logic in_range;
	logic [ADDR_W-1:0] base;

	// ----------------------------------------------------------------
	// Window and base per function code
	// ----------------------------------------------------------------
	always_comb
	begin
		known = 1'b1;
		is_write = 1'b0;
		in_range = 1'b0;
		base = '0;
		case (i_func)
			MRB_FC_RD_COIL:
			begin
				in_range = in_win(i_maddr, MRB_COIL_LO, MRB_COIL_HI);
				base = ADDR_W'(MRB_COIL_LO);
			end
			MRB_FC_RD_INBIT:
			begin
				in_range = in_win(i_maddr, MRB_INBIT_LO, MRB_INBIT_HI);
				base = ADDR_W'(MRB_INBIT_LO);
			end
			MRB_FC_RD_HOLD:
			begin
				in_range = in_win(i_maddr, MRB_HOLD_LO, MRB_HOLD_HI);
				base = ADDR_W'(MRB_HOLD_LO);
			end
			MRB_FC_RD_INREG:
			begin
				in_range = in_win(i_maddr, MRB_INREG_LO, MRB_INREG_HI);
				base = ADDR_W'(MRB_INREG_LO);
			end
			MRB_FC_WR_COIL, MRB_FC_WR_COILS:
			begin
				is_write = 1'b1;
				in_range = in_win(i_maddr, MRB_COIL_LO, MRB_COIL_HI);
				base = ADDR_W'(MRB_COIL_LO);
			end
			MRB_FC_WR_REG:
			begin
				is_write = 1'b1;
				in_range = in_win(i_maddr, MRB_HOLD_LO, MRB_HOLD_HI);
				base = ADDR_W'(MRB_HOLD_LO);
			end
			MRB_FC_WR_REGS:
			begin
				is_write = 1'b1;
				in_range = in_win(i_maddr, MRB_HOLD_LO, MRB_HOLDM_HI);
				base = ADDR_W'(MRB_HOLD_LO);
			end
			default: known = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Verdict, first failing check wins
	// ----------------------------------------------------------------
	assign o_bcast = (i_node == MRB_NODE_BCAST);
	always_comb
	begin
		if (!known)
			o_err = MRB_ERR_FUNC;
		else if (o_bcast && !is_write)
			o_err = MRB_ERR_BCAST;
		else if (!o_bcast && (i_node < MRB_NODE_MIN || i_node > MRB_NODE_MAX))
			o_err = MRB_ERR_NODE;
		else if (!in_range)
			o_err = MRB_ERR_RANGE;
		else
			o_err = MRB_ERR_NONE;
	end
	assign o_ok = (o_err == MRB_ERR_NONE);
	// Zero-based offset; windows are all below 65536 so the cut is lossless
	assign o_remote_offset = 16'(i_maddr - base);
endmodule // mrb_addr_map

// ### rtl/mrb_builder.sv
// Modbus master request builder with AXI4-Lite registers and receive reordering
// What this block does
// - Reorder ABCD as ABCD, CDAB, DCBA, BADC
// - Reorder read data per four-byte group before storing
// - Individual node addresses only 1 through 247
// - Node 0 only for broadcast write commands
// - Function 1 reads coils 0001 to 9999
// - Function 2 reads input bits 10001 to 29999
// - Function 3 reads holding registers 40001 to 47999
// - Function 4 reads input registers 30001 to 39999
// - Function 5 writes one coil 0001 to 9999
// - Function 6 writes one register 40001 to 47999
// - Function 15 writes coils 0001 to 9999
// - Function 16 writes registers 40001 to 49999
// - Function byte then two-byte zero-based offset
// - Coil functions offset is address minus 0001
// - Function 2 offset is address minus 10001
// - Holding functions offset is address minus 40001
// - Function 4 offset is address minus 30001
`timescale 1ns/100ps
module mrb_builder
	import mrb_pkg::*;
#(
	parameter int ADDR_W = 17
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [7:0] o_tx_data,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic [31:0] i_rx_word,
	input wire logic i_rx_valid,
	output logic [31:0] o_store_data,
	output logic o_store_valid
);
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} mrb_state_e;

	// The mapper takes a printed address of 17 to 32 bits, though the highest printed address, 49999, fits in 16
	if (ADDR_W < 17 || ADDR_W > 32)
	begin : g_chk
		$error("ADDR_W must be 17 to 32");
	end

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// Register offset known to the map
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == MRB_OFF_CTRL) || (a == MRB_OFF_CMD) || (a == MRB_OFF_ADDR) ||
			(a == MRB_OFF_STAT) || (a == MRB_OFF_OFFS) || (a == MRB_OFF_RXD);
	endfunction

	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] cmd_reg, addr_reg, rxd_reg, frame_reg, store_reg;
	logic [15:0] offs_reg;
	logic [3:0] err_code_reg;
	logic done_reg, err_reg, bcast_reg, store_vld_reg;
	logic [1:0] idx_reg;
	mrb_state_e state_reg;
	logic do_write, start, tx_fire;
	logic map_ok, map_bcast;
	logic [3:0] map_err;
	logic [15:0] map_offset;
	logic [31:0] swapped;
	logic [1:0] cfg_swap;
	logic [7:0] cfg_node, cfg_func;

	assign cfg_swap = cmd_reg[MRB_CMD_SWAP_LSB +: 2];
	assign cfg_node = cmd_reg[MRB_CMD_NODE_LSB +: 8];
	assign cfg_func = cmd_reg[MRB_CMD_FUNC_LSB +: 8];

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Address and data are taken in either order; nothing new until the response leaves
	assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign o_s_axi_wready = !w_held_reg && !bvalid_reg;
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp = bresp_reg;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= MRB_RESP_OKAY;
		end
		else
		begin
			if (i_s_axi_awvalid && o_s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= i_s_axi_wdata;
				w_strb_reg <= i_s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= mapped(aw_addr_reg) ? MRB_RESP_OKAY : MRB_RESP_SLVERR;
			end
			else if (bvalid_reg && i_s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Command registers; a write lands while the frame is out, the frame already latched is unaffected
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			cmd_reg <= MRB_CMD_RESET;
			addr_reg <= MRB_ADDR_RESET;
		end
		else if (do_write)
		begin
			if (aw_addr_reg == MRB_OFF_CMD)
				cmd_reg <= merge(cmd_reg, w_data_reg, w_strb_reg);
			if (aw_addr_reg == MRB_OFF_ADDR)
				addr_reg <= merge(addr_reg, w_data_reg, w_strb_reg);
		end
	end

	// Start is a pulse; ignored while a frame is still going out
	assign start = do_write && (aw_addr_reg == MRB_OFF_CTRL) && w_strb_reg[0] &&
		w_data_reg[MRB_CTRL_START] && (state_reg == ST_IDLE);

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign o_s_axi_arready = !rvalid_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata = rdata_reg;
	assign o_s_axi_rresp = rresp_reg;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= MRB_RESP_OKAY;
		end
		else if (i_s_axi_arvalid && o_s_axi_arready)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg <= mapped(i_s_axi_araddr) ? MRB_RESP_OKAY : MRB_RESP_SLVERR;
			case (i_s_axi_araddr)
				MRB_OFF_CMD: rdata_reg <= cmd_reg;
				MRB_OFF_ADDR: rdata_reg <= addr_reg;
				MRB_OFF_STAT:
				begin
					rdata_reg <= '0;
					rdata_reg[MRB_STAT_BUSY] <= (state_reg == ST_SEND);
					rdata_reg[MRB_STAT_DONE] <= done_reg;
					rdata_reg[MRB_STAT_ERR] <= err_reg;
					rdata_reg[MRB_STAT_BCAST] <= bcast_reg;
					rdata_reg[MRB_STAT_CODE_LSB +: 4] <= err_code_reg;
				end
				MRB_OFF_OFFS: rdata_reg <= {16'h0000, offs_reg};
				MRB_OFF_RXD: rdata_reg <= rxd_reg;
				default: rdata_reg <= '0;
			endcase
		end
		else if (rvalid_reg && i_s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Request checking and framing
	// ----------------------------------------------------------------
	mrb_addr_map #(.ADDR_W(ADDR_W)) u_map (
		.i_func(cfg_func),
		.i_node(cfg_node),
		.i_maddr(addr_reg[ADDR_W-1:0]),
		.o_ok(map_ok),
		.o_err(map_err),
		.o_bcast(map_bcast),
		.o_remote_offset(map_offset)
	);

	assign tx_fire = (state_reg == ST_SEND) && i_tx_ready;
	assign o_tx_valid = (state_reg == ST_SEND);
	assign o_tx_data = frame_reg[31:24];

	// Frame is node, function, offset high, offset low, shifted out from the top byte
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			state_reg <= ST_IDLE;
			frame_reg <= '0;
			idx_reg <= '0;
		end
		else
		case (state_reg)
			ST_IDLE:
				if (start && map_ok)
				begin
					frame_reg <= {cfg_node, cfg_func, map_offset};
					idx_reg <= '0;
					state_reg <= ST_SEND;
				end
			ST_SEND:
				if (tx_fire)
				begin
					frame_reg <= {frame_reg[23:0], 8'h00};
					idx_reg <= idx_reg + 2'd1;
					if (idx_reg == MRB_LAST_BYTE)
						state_reg <= ST_IDLE;
				end
			default: state_reg <= ST_IDLE;
		endcase
	end

	// Status; an accepted start clears done, which can never coincide with the set
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			bcast_reg <= 1'b0;
			err_code_reg <= MRB_ERR_NONE;
			offs_reg <= '0;
		end
		else if (start)
		begin
			done_reg <= !map_ok; // refused commands finish at once
			err_reg <= !map_ok;
			err_code_reg <= map_err;
			bcast_reg <= map_bcast && map_ok;
			offs_reg <= map_offset;
		end
		else if (tx_fire && idx_reg == MRB_LAST_BYTE)
			done_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Receive path, one group per valid
	// ----------------------------------------------------------------
	mrb_swap u_swap (
		.i_swap(cfg_swap),
		.i_word(i_rx_word),
		.o_word(swapped)
	);

	assign o_store_data = store_reg;
	assign o_store_valid = store_vld_reg;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			store_reg <= '0;
			store_vld_reg <= 1'b0;
			rxd_reg <= '0;
		end
		else
		begin
			store_vld_reg <= i_rx_valid;
			if (i_rx_valid)
			begin
				store_reg <= swapped;
				rxd_reg <= swapped;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_swap_none;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rx_valid && cfg_swap == MRB_SWAP_NONE |=> o_store_data == $past(i_rx_word);
	endproperty
	a_swap_none: assert property (p_swap_none) else $error("swap 0 wrong");

	property p_swap_word;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rx_valid && cfg_swap == MRB_SWAP_WORD |=> o_store_data == {$past(i_rx_word[15:0]), $past(i_rx_word[31:16])};
	endproperty
	a_swap_word: assert property (p_swap_word) else $error("swap 1 wrong");

	property p_swap_all;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rx_valid && cfg_swap == MRB_SWAP_ALL |=> o_store_data == {$past(i_rx_word[7:0]), $past(i_rx_word[15:8]),
			$past(i_rx_word[23:16]), $past(i_rx_word[31:24])};
	endproperty
	a_swap_all: assert property (p_swap_all) else $error("swap 2 wrong");

	property p_store_follows;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_store_valid == $past(i_rx_valid);
	endproperty
	a_store_follows: assert property (p_store_follows) else $error("store strobe lost");

	property p_bad_node;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		start && cfg_node > MRB_NODE_MAX |=> !o_tx_valid && err_reg && done_reg;
	endproperty
	a_bad_node: assert property (p_bad_node) else $error("bad node sent");

	property p_bcast_read;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		start && cfg_node == MRB_NODE_BCAST && cfg_func == MRB_FC_RD_HOLD |=> !o_tx_valid && err_code_reg == MRB_ERR_BCAST;
	endproperty
	a_bcast_read: assert property (p_bcast_read) else $error("broadcast read sent");

	property p_bad_func;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		start && cfg_func == 8'h07 |=> !o_tx_valid && err_code_reg == MRB_ERR_FUNC;
	endproperty
	a_bad_func: assert property (p_bad_func) else $error("unknown function sent");

	property p_order;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		start && map_ok ##1 tx_fire |-> o_tx_data == $past(cfg_node) ##1 (o_tx_valid && o_tx_data == $past(cfg_func, 2));
	endproperty
	a_order: assert property (p_order) else $error("node or function byte misplaced");

	property p_hold_zero;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		start && map_ok && cfg_func == MRB_FC_RD_HOLD && addr_reg == 32'h0000_9C41 |=> offs_reg == 16'h0000;
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("40001 not offset zero");

	property p_four_bytes;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		tx_fire && idx_reg == MRB_LAST_BYTE |=> !o_tx_valid && done_reg;
	endproperty
	a_four_bytes: assert property (p_four_bytes) else $error("frame not four bytes");
endmodule // mrb_builder

// ### testbench/mrb_slave_model.sv
// Far side model: takes request bytes and returns received four-byte groups
`timescale 1ns/100ps
module mrb_slave_model
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_slow,
	output logic o_tx_ready,
	output logic [31:0] o_rx_word,
	output logic o_rx_valid
);
	initial
	begin
		o_tx_ready = 1'b0;
		o_rx_word = 32'h0000_0000;
		o_rx_valid = 1'b0;
	end
	// Slow mode stalls every other cycle so the request must hold
	always @(posedge i_clk)
		o_tx_ready <= !i_rst_n ? 1'b0 : (i_slow ? !o_tx_ready : 1'b1);
	// Two groups back to back; the line then shows the inverse, not stale data
	task send2(input logic [31:0] w0, input logic [31:0] w1);
		o_rx_word <= w0;
		o_rx_valid <= 1'b1;
		@(posedge i_clk);
		o_rx_word <= w1;
		@(posedge i_clk);
		o_rx_word <= ~w1;
		o_rx_valid <= 1'b0;
	endtask
endmodule // mrb_slave_model

// ### testbench/mrb_builder_bench.sv
// Testbench for the request builder: register tasks, request and receive checks
`timescale 1ns/100ps
module mrb_builder_bench;
	import mrb_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, rx_valid, store_valid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rx_word, store_data, t;
	logic [7:0] tx_data;
	logic [7:0] q[$];
	logic [31:0] sq[$];
	int fail_count = 0;
	int n_tests = 0;
	// ----------------------------------------------------------------
	// Clock, design, far side
	// ----------------------------------------------------------------
	initial
	begin
		forever #5 clk = ~clk;
	end
	mrb_builder uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_tx_data(tx_data),
		.o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .i_rx_word(rx_word), .i_rx_valid(rx_valid),
		.o_store_data(store_data), .o_store_valid(store_valid));
	mrb_slave_model model (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .o_tx_ready(tx_ready),
		.o_rx_word(rx_word), .o_rx_valid(rx_valid));
	// Record every byte taken and every stored group
	always @(posedge clk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			q.push_back(tx_data);
		if (store_valid === 1'b1)
			sq.push_back(store_data);
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Write: both channels offered, each dropped when taken, bready held until bvalid
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		bready <= 1'b0;
		chk("bresp", 32'(bresp), 32'(er));
	endtask
	task rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		t = rdata;
		rready <= 1'b0;
		chk("rresp", 32'(rresp), 32'(er));
	endtask
	function automatic logic [31:0] sw(input logic [1:0] s, input logic [31:0] w);
		case (s)
			2'h0: return w;
			2'h1: return {w[15:0], w[31:16]};
			2'h2: return {w[7:0], w[15:8], w[23:16], w[31:24]};
			default: return {w[23:16], w[31:24], w[7:0], w[15:8]};
		endcase
	endfunction
	// One command: build, wait for done, compare the bytes, offset and status
	task cmd(input logic [7:0] f, input logic [7:0] n, input int a, input logic [15:0] eo, input logic [3:0] ec);
		q.delete();
		wr(MRB_OFF_CMD, {16'h0000, n, f}, MRB_RESP_OKAY);
		wr(MRB_OFF_ADDR, 32'(a), MRB_RESP_OKAY);
		wr(MRB_OFF_CTRL, 32'h0000_0001, MRB_RESP_OKAY);
		for (int k = 0; k < 40; k++)
		begin
			rd(MRB_OFF_STAT, MRB_RESP_OKAY);
			if (t[MRB_STAT_DONE] === 1'b1)
				break;
		end
		chk("nbytes", 32'(q.size()), (ec == MRB_ERR_NONE) ? 32'h0000_0004 : 32'h0000_0000);
		if (ec == MRB_ERR_NONE)
		begin
			chk("stat", t & 32'h0000_00FE, {28'h0, (n == MRB_NODE_BCAST), 3'b010});
			chk("frame", {q[0], q[1], q[2], q[3]}, {n, f, eo});
			rd(MRB_OFF_OFFS, MRB_RESP_OKAY);
			chk("offs", t, 32'(eo));
		end
		else
			chk("stat", t & 32'h0000_00F6, {24'h0, ec, 4'b0110});
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		#300000;
		fail_count++;
		summarize();
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(MRB_OFF_CMD, MRB_RESP_OKAY);
		chk("cmd_rst", t, MRB_CMD_RESET);
		rd(MRB_OFF_ADDR, MRB_RESP_OKAY);
		chk("addr_rst", t, MRB_ADDR_RESET);
		wr(8'h20, 32'h0000_0001, MRB_RESP_SLVERR);
		rd(8'h20, MRB_RESP_SLVERR);
		chk("unmapped", t, 32'h0000_0000);
		cmd(MRB_FC_RD_COIL, 8'h01, 1, 16'd0, MRB_ERR_NONE);
		cmd(MRB_FC_RD_INBIT, 8'hF7, 10345, 16'd344, MRB_ERR_NONE);
		slow <= 1'b1;
		cmd(MRB_FC_RD_HOLD, 8'h01, 40001, 16'd0, MRB_ERR_NONE);
		cmd(MRB_FC_RD_INREG, 8'h02, 34290, 16'd4289, MRB_ERR_NONE);
		cmd(MRB_FC_WR_COIL, 8'h00, 9999, 16'd9998, MRB_ERR_NONE);
		slow <= 1'b0;
		cmd(MRB_FC_WR_REG, 8'h05, 47999, 16'd7998, MRB_ERR_NONE);
		cmd(MRB_FC_WR_COILS, 8'h07, 1378, 16'd1377, MRB_ERR_NONE);
		cmd(MRB_FC_WR_REGS, 8'h00, 49999, 16'd9998, MRB_ERR_NONE);
		cmd(8'h07, 8'h01, 40001, 16'd0, MRB_ERR_FUNC);
		cmd(MRB_FC_RD_HOLD, 8'hF8, 40001, 16'd0, MRB_ERR_NODE);
		cmd(MRB_FC_RD_HOLD, 8'h00, 40001, 16'd0, MRB_ERR_BCAST);
		cmd(MRB_FC_RD_HOLD, 8'h01, 48000, 16'd0, MRB_ERR_RANGE);
		cmd(MRB_FC_WR_REG, 8'h01, 49999, 16'd0, MRB_ERR_RANGE);
		cmd(MRB_FC_RD_INREG, 8'h01, 40001, 16'd0, MRB_ERR_RANGE);
		rd(MRB_OFF_CMD, MRB_RESP_OKAY);
		chk("cmd_rb", t, {16'h0000, 8'h01, MRB_FC_RD_INREG});
		// Every byte order on two groups back to back
		for (int s = 0; s < 4; s++)
		begin
			wr(MRB_OFF_CMD, {6'h00, 2'(s), 24'h000001}, MRB_RESP_OKAY);
			sq.delete();
			@(posedge clk);
			model.send2(32'h1122_3344, 32'hA1B2_C3D4);
			repeat (2) @(posedge clk);
			chk("store0", sq[0], sw(2'(s), 32'h1122_3344));
			chk("store1", sq[1], sw(2'(s), 32'hA1B2_C3D4));
			rd(MRB_OFF_RXD, MRB_RESP_OKAY);
			chk("rxd", t, sw(2'(s), 32'hA1B2_C3D4));
		end
		summarize();
	end
endmodule // mrb_builder_bench
